// *** rtl/cfrb_addr_gen.sv ***
`timescale 1ns/10ps
module cfrb_addr_gen
    import cfrb_pkg::*;
(
    input  wire logic [4:0]  i_bank,
    input  wire logic [2:0]  i_idx,
    output logic      [15:0] o_addr
);
    // bank pointer times eight plus index, over the fixed base
    assign o_addr = BANK_BASE + {8'h00, i_bank, i_idx};
endmodule

// *** rtl/cfrb_core.sv ***
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// - half-carry set on carry or borrow between bit 3 and bit 4
// - half-carry feeds the decimal adjust operations
// - interrupts accepted only while the enable flag is one
// - reset clears the interrupt enable flag
// - request serviced only if its level beats the two-bit mask
// - negative flag follows result bit 7
// - zero flag set when the result is zero
// - overflow flag set on signed two's-complement overflow
// - carry flag set on carry or borrow out of bit 7
// - shifts load carry with the bit shifted out
// - general registers are 8 bits, in data memory, eight per bank
// - up to 32 banks chosen by the bank pointer
module cfrb_core
    import cfrb_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_op,
    input  wire logic [7:0]  i_a,
    input  wire logic [7:0]  i_b,
    input  wire logic [2:0]  i_reg_idx,
    input  wire logic        i_irq_req,
    input  wire logic [1:0]  i_irq_level,
    input  wire logic [1:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    output logic      [7:0]  o_result,
    output logic      [7:0]  o_ccr,
    output logic      [15:0] o_reg_addr,
    output logic             o_irq_accept
);

    ////////////////////////////////////////////////////////////////////////////
    // flags are kept per concern: the arithmetic flags follow the datapath,
    // the enable and the mask change only through a software write
    logic        h_reg;
    logic        h_next;
    logic        n_reg;
    logic        z_reg;
    logic        v_reg;
    logic        v_next;
    logic        c_reg;
    logic        c_next;
    logic        ie_reg;
    logic [1:0]  mask_reg;
    logic [7:0]  ccr_word;
    logic        ccr_wr;
    logic        bank_wr;
    logic [4:0]  bank_reg;
    logic [7:0]  result_reg;
    logic [7:0]  result_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        flags_upd;
    cfrb_op_e    op;

    // adder and subtractor
    logic        add_sub;
    logic        add_cin;
    logic [8:0]  add_sum9;
    logic [4:0]  add_sum5;
    logic [7:0]  add_res;
    logic        add_c;
    logic        add_h;
    logic        add_v;

    // shifter
    logic [7:0]  sh_res;
    logic        sh_c;

    // decimal adjust
    logic [7:0]  dec_adj;
    logic [8:0]  dec_sum9;
    logic [7:0]  dec_res;
    logic        dec_c;

    ////////////////////////////////////////////////////////////////////////////
    // register port write decode, shared by the flag and bank registers
    function automatic logic port_write(input logic       wr,
                                        input logic [1:0] addr,
                                        input logic [1:0] target);
        return wr && (addr == target);
    endfunction

    // operations that run through the adder and own the h and v flags
    function automatic logic is_arith(input cfrb_op_e code);
        return (code == CFRB_OP_ADD) || (code == CFRB_OP_ADC)
            || (code == CFRB_OP_SUB) || (code == CFRB_OP_SBC);
    endfunction

    // operations that chain in the carry of the previous one
    function automatic logic uses_carry(input cfrb_op_e code);
        return (code == CFRB_OP_ADC) || (code == CFRB_OP_SBC);
    endfunction

    assign op      = cfrb_op_e'(i_op);
    assign ccr_wr  = port_write(i_wr, i_addr, ADDR_CCR);
    assign bank_wr = port_write(i_wr, i_addr, ADDR_BANK);
    assign add_sub = (op == CFRB_OP_SUB) || (op == CFRB_OP_SBC);
    assign add_cin = uses_carry(op) && c_reg;

    ////////////////////////////////////////////////////////////////////////////
    // carry out of subtraction is the borrow, as the bcd adjust expects
    always_comb begin
        if (add_sub) begin
            add_sum9 = {1'b0, i_a} - {1'b0, i_b} - {8'h00, add_cin};
            add_sum5 = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, add_cin};
        end else begin
            add_sum9 = {1'b0, i_a} + {1'b0, i_b} + {8'h00, add_cin};
            add_sum5 = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, add_cin};
        end
        add_res = add_sum9[7:0];
        add_c   = add_sum9[8];
        add_h   = add_sum5[4];
        add_v   = add_sub ? ((i_a[7] != i_b[7]) && (add_sum9[7] != i_a[7]))
                          : ((i_a[7] == i_b[7]) && (add_sum9[7] != i_a[7]));
    end

    ////////////////////////////////////////////////////////////////////////////
    // rotates pass through the old carry, plain shifts bring in zero
    always_comb begin
        sh_res = i_a;
        sh_c   = c_reg;
        unique case (op)
            CFRB_OP_SHL: begin
                sh_res = {i_a[6:0], 1'b0};
                sh_c   = i_a[7];
            end
            CFRB_OP_SHR: begin
                sh_res = {1'b0, i_a[7:1]};
                sh_c   = i_a[0];
            end
            CFRB_OP_ROL: begin
                sh_res = {i_a[6:0], c_reg};
                sh_c   = i_a[7];
            end
            CFRB_OP_ROR: begin
                sh_res = {c_reg, i_a[7:1]};
                sh_c   = i_a[0];
            end
            default: begin
                sh_res = i_a;
                sh_c   = c_reg;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // bcd correction relies on the stored half-carry and carry
    always_comb begin
        dec_adj = 8'h00;
        if (op == CFRB_OP_DAS) begin
            dec_adj[3:0] = h_reg ? 4'h6 : 4'h0;
            dec_adj[7:4] = c_reg ? 4'h6 : 4'h0;
            dec_sum9     = {1'b0, i_a} - {1'b0, dec_adj};
            dec_c        = c_reg;
        end else begin
            // after an add a digit above nine needs the same correction
            dec_adj[3:0] = (h_reg || i_a[3:0] > 4'h9) ? 4'h6 : 4'h0;
            dec_adj[7:4] = (c_reg || i_a > 8'h99) ? 4'h6 : 4'h0;
            dec_sum9     = {1'b0, i_a} + {1'b0, dec_adj};
            dec_c        = c_reg || (i_a > 8'h99);
        end
        dec_res = dec_sum9[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // result and flag select; unknown codes leave everything as it was
    always_comb begin
        result_next = result_reg;
        c_next      = c_reg;
        h_next      = h_reg;
        v_next      = v_reg;
        flags_upd   = 1'b1;
        if (is_arith(op)) begin
            result_next = add_res;
            c_next      = add_c;
            h_next      = add_h;
            v_next      = add_v;
        end else begin
            unique case (op)
                CFRB_OP_SHL, CFRB_OP_SHR, CFRB_OP_ROL, CFRB_OP_ROR: begin
                    result_next = sh_res;
                    c_next      = sh_c;
                end
                CFRB_OP_DAA, CFRB_OP_DAS: begin
                    result_next = dec_res;
                    c_next      = dec_c;
                end
                default: begin
                    flags_upd = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // a software write of the flag byte wins over an operation in the same cycle

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            h_reg <= CC_RESET[CC_H];
        end else if (ccr_wr) begin
            h_reg <= i_wdata[CC_H];
        end else if (flags_upd) begin
            h_reg <= h_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            n_reg <= CC_RESET[CC_N];
        end else if (ccr_wr) begin
            n_reg <= i_wdata[CC_N];
        end else if (flags_upd) begin
            n_reg <= result_next[7];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            z_reg <= CC_RESET[CC_Z];
        end else if (ccr_wr) begin
            z_reg <= i_wdata[CC_Z];
        end else if (flags_upd) begin
            z_reg <= (result_next == 8'h00);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            v_reg <= CC_RESET[CC_V];
        end else if (ccr_wr) begin
            v_reg <= i_wdata[CC_V];
        end else if (flags_upd) begin
            v_reg <= v_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            c_reg <= CC_RESET[CC_C];
        end else if (ccr_wr) begin
            c_reg <= i_wdata[CC_C];
        end else if (flags_upd) begin
            c_reg <= c_next;
        end
    end

    // interrupts start out disabled until software sets the enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ie_reg <= CC_RESET[CC_I];
        end else if (ccr_wr) begin
            ie_reg <= i_wdata[CC_I];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mask_reg <= {CC_RESET[CC_IL1], CC_RESET[CC_IL0]};
        end else if (ccr_wr) begin
            mask_reg <= {i_wdata[CC_IL1], i_wdata[CC_IL0]};
        end
    end

    // the flag byte as software and the outside see it
    always_comb begin
        ccr_word         = 8'h00;
        ccr_word[CC_H]   = h_reg;
        ccr_word[CC_I]   = ie_reg;
        ccr_word[CC_IL1] = mask_reg[1];
        ccr_word[CC_IL0] = mask_reg[0];
        ccr_word[CC_N]   = n_reg;
        ccr_word[CC_Z]   = z_reg;
        ccr_word[CC_V]   = v_reg;
        ccr_word[CC_C]   = c_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            result_reg <= 8'h00;
        end else begin
            result_reg <= result_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bank_reg <= BANK_RESET;
        end else if (bank_wr) begin
            bank_reg <= i_wdata[4:0];
        end
    end

    // read data stand one cycle after each cycle of the read strobe and are zero otherwise
    always_comb begin
        rdata_next = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_CCR:    rdata_next = ccr_word;
                ADDR_BANK:   rdata_next = {3'h0, bank_reg};
                ADDR_RESULT: rdata_next = result_reg;
                default:     rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level 00 is highest; a request needs a strictly smaller code than the mask
    assign o_irq_accept = i_irq_req && ie_reg
                       && (i_irq_level < mask_reg);

    assign o_rdata  = rdata_reg;
    assign o_result = result_reg;
    assign o_ccr    = ccr_word;

    // registers themselves live in data memory; only the address is made here
    cfrb_addr_gen u_addr_gen (
        .i_bank (bank_reg),
        .i_idx  (i_reg_idx),
        .o_addr (o_reg_addr)
    );

endmodule

// *** rtl/cfrb_pkg.sv ***
package cfrb_pkg;

    localparam int DATA_W       = 8;
    localparam int BANK_W       = 5;
    localparam int NUM_BANKS    = 32;
    localparam int REGS_PER_BANK = 8;
    localparam int REG_IDX_W    = 3;
    localparam int ADDR_W       = 16;

    // fixed base of the register banks in data memory
    localparam logic [15:0] BANK_BASE = 16'h0100;

    // condition code field positions
    localparam int CC_C   = 0;
    localparam int CC_V   = 1;
    localparam int CC_Z   = 2;
    localparam int CC_N   = 3;
    localparam int CC_IL0 = 4;
    localparam int CC_IL1 = 5;
    localparam int CC_I   = 6;
    localparam int CC_H   = 7;

    localparam logic [7:0] CC_RESET   = 8'h30;
    localparam logic [4:0] BANK_RESET = 5'h00;

    // register offsets on the plain register port
    localparam logic [1:0] ADDR_CCR  = 2'h0;
    localparam logic [1:0] ADDR_BANK = 2'h1;
    localparam logic [1:0] ADDR_RESULT = 2'h2;

    typedef enum logic [3:0] {
        CFRB_OP_NONE,
        CFRB_OP_ADD,
        CFRB_OP_ADC,
        CFRB_OP_SUB,
        CFRB_OP_SBC,
        CFRB_OP_SHL,
        CFRB_OP_SHR,
        CFRB_OP_ROL,
        CFRB_OP_ROR,
        CFRB_OP_DAA,
        CFRB_OP_DAS
    } cfrb_op_e;

endpackage

// *** sim/cfrb_core_chk.sv ***
`timescale 1ns/10ps
module cfrb_core_chk
    import cfrb_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic [3:0] i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic [1:0] i_addr,
    input wire logic       i_wr,
    input wire logic       i_irq_req,
    input wire logic [1:0] i_irq_level,
    input wire logic [7:0] o_result,
    input wire logic [7:0] o_ccr,
    input wire logic       o_irq_accept
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // a same-edge ccr write wins over the op, so those edges are left out
    wire logic  fr = !i_rst && !(i_wr && i_addr == ADDR_CCR);
    logic       ar_q, ad_q, sh_q;
    logic [7:0] a_q, b_q;
    always_ff @(posedge i_clk) begin
        ar_q <= fr && i_op inside {[4'h1:4'h4]};
        ad_q <= fr && i_op == CFRB_OP_ADD;
        sh_q <= fr && i_op == CFRB_OP_SHL;
        a_q  <= i_a;
        b_q  <= i_b;
    end
    zero_flag_a: assert property (ar_q |->
        o_ccr[CC_Z] == (o_result == 8'h00)) else $error("bad zero flag");
    add_carry_a: assert property (ad_q |->
        o_ccr[CC_C] == (a_q + b_q > 9'h0ff)) else $error("bad carry");
    half_carry_a: assert property (ad_q |->
        o_ccr[CC_H] == (a_q[3:0] + b_q[3:0] > 5'h0f)) else $error("bad half carry");
    overflow_a: assert property (ad_q |->
        o_ccr[CC_V] == (a_q[7] == b_q[7] && o_result[7] != a_q[7])) else $error("bad overflow");
    shift_carry_a: assert property (sh_q |->
        o_ccr[CC_C] == a_q[7]) else $error("bad shift carry");
    irq_block_a: assert property (!o_ccr[CC_I] |-> !o_irq_accept)
        else $error("irq taken while disabled");
    irq_level_a: assert property (o_irq_accept |->
        i_irq_req && i_irq_level < o_ccr[CC_IL1:CC_IL0]) else $error("bad irq level");
    reset_clear_a: assert property ($past(i_rst) |->
        !o_ccr[CC_I] && !o_irq_accept) else $error("irq enabled after reset");
endmodule
bind cfrb_core cfrb_core_chk chk (.i_clk, .i_rst, .i_op, .i_a, .i_b, .i_addr, .i_wr,
    .i_irq_req, .i_irq_level, .o_result, .o_ccr, .o_irq_accept);

// *** sim/cfrb_core_tb.sv ***
`timescale 1ns/10ps
module cfrb_core_tb
    import cfrb_pkg::*;
;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_irq_req = 1'b0;
    logic [3:0]  i_op = 4'h0;
    logic [7:0]  i_a = 8'h00, i_b = 8'h00, i_wdata = 8'h00, o_rdata, o_result, o_ccr;
    logic [2:0]  i_reg_idx = 3'h0;
    logic [1:0]  i_irq_level = 2'h0, i_addr = 2'h0;
    logic [15:0] o_reg_addr;
    logic        o_irq_accept;
    int          bad_count = 0, check_count = 0, cyc = 0;
    always #12.5 i_clk = ~i_clk;
    cfrb_core dut (.i_clk, .i_rst, .i_op, .i_a, .i_b, .i_reg_idx, .i_irq_req, .i_irq_level,
        .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_result, .o_ccr, .o_reg_addr, .o_irq_accept);
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge i_clk) if (++cyc == 2000) begin
        bad_count++;
        report_and_stop();
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, o_rdata});
    endtask
    // shifts leave h and v alone, decimal adjust is judged on its result only
    task automatic op(input logic [3:0] o, input logic [7:0] a, b, r, f);
        logic [7:0] m;
        m = (o > 4'h8) ? 8'h00 : (o > 4'h4) ? 8'h0d : 8'h8f;
        @(posedge i_clk);
        i_op <= o;
        i_a <= a;
        i_b <= b;
        @(posedge i_clk);
        i_op <= CFRB_OP_NONE;
        #1 chk("result flags", {r, f & m}, {o_result, o_ccr & m});
    endtask
    task automatic t_reset();
        i_irq_req <= 1'b1;
        rd(ADDR_CCR, CC_RESET);
        chk("accept", 16'h0000, {15'h0, o_irq_accept});
        $display("end reset test");
    endtask
    task automatic t_flags();
        op(CFRB_OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h8a);
        op(CFRB_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h85);
        op(CFRB_OP_ADC, 8'h00, 8'h00, 8'h01, 8'h00);
        op(CFRB_OP_SUB, 8'h00, 8'h01, 8'hff, 8'h89);
        op(CFRB_OP_SBC, 8'h05, 8'h01, 8'h03, 8'h00);
        op(CFRB_OP_SHL, 8'h81, 8'h00, 8'h02, 8'h01);
        op(CFRB_OP_SHR, 8'h01, 8'h00, 8'h00, 8'h05);
        op(CFRB_OP_ROL, 8'h80, 8'h00, 8'h01, 8'h01);
        op(CFRB_OP_ROR, 8'h01, 8'h00, 8'h80, 8'h09);
        op(CFRB_OP_ADD, 8'h08, 8'h08, 8'h10, 8'h80);
        op(CFRB_OP_DAA, 8'h10, 8'h00, 8'h16, 8'h00);
        op(CFRB_OP_SUB, 8'h10, 8'h01, 8'h0f, 8'h80);
        op(CFRB_OP_DAS, 8'h0f, 8'h00, 8'h09, 8'h00);
        rd(ADDR_RESULT, 8'h09);
        $display("end flags test");
    endtask
    task automatic t_irq();
        wr(ADDR_CCR, 8'h60);
        rd(ADDR_CCR, 8'h60);
        for (int l = 0; l < 4; l++) begin
            @(posedge i_clk);
            i_irq_level <= l[1:0];
            #1 chk("accept", {15'h0, l < 2}, {15'h0, o_irq_accept});
        end
        @(posedge i_clk);
        i_irq_level <= 2'h0;
        wr(ADDR_CCR, 8'h20);
        #1 chk("accept", 16'h0000, {15'h0, o_irq_accept});
        $display("end irq test");
    endtask
    task automatic t_bank();
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_BANK, k[1] ? 8'h1f : 8'h00);
            i_reg_idx <= k[0] ? 3'h7 : 3'h0;
            @(posedge i_clk);
            #1 chk("reg addr", BANK_BASE + (k[1] ? 16'h00f8 : 16'h0000) + 16'(k[0] * 7),
                o_reg_addr);
        end
        rd(ADDR_BANK, 8'h1f);
        rd(2'h3, 8'h00);
        $display("end bank test");
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_flags();
        t_irq();
        t_bank();
        report_and_stop();
    end
endmodule
